/* File: hdl/pmx_slot_exchange_regs.vh */
`ifndef PMX_SLOT_EXCHANGE_REGS_VH
`define PMX_SLOT_EXCHANGE_REGS_VH

// ----------------------------------------------------------------
// apb register offsets
// ----------------------------------------------------------------
`define PMX_CTRL_OFS        8'h00
`define PMX_STAT_OFS        8'h04
`define PMX_ROT_OFS         8'h08
`define PMX_LOAD_OFS        8'h0c

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define PMX_CTRL_FMT_LSB    0
`define PMX_CTRL_BT_BIT     2
`define PMX_CTRL_SQ_LSB     3
`define PMX_CTRL_NS_LSB     5
`define PMX_CTRL_RST        8'h20

// data formats
`define PMX_FMT_INT         2'h0
`define PMX_FMT_DIV         2'h1
`define PMX_FMT_FLT         2'h2

// ----------------------------------------------------------------
// float command codes (low byte of the command word)
// ----------------------------------------------------------------
`define PMX_CMD_NEXT_A      8'h01
`define PMX_CMD_NEXT_B      8'h02
`define PMX_CMD_AUTO        8'h03
`define PMX_CMD_CLR_ROT     8'h05
`define PMX_CMD_LD_TARGET   8'h06
`define PMX_CMD_LD_TARE     8'h07
`define PMX_CMD_ADD_ROT     8'h08
`define PMX_CMD_REPORT      5'h02

// reported quantities
`define PMX_FLD_GROSS       3'h0
`define PMX_FLD_NET         3'h1
`define PMX_FLD_TARE        3'h2
`define PMX_FLD_TARGET      3'h3
`define PMX_FLD_FEED        3'h4
`define PMX_FLD_TOL         3'h5

// reporting modes
`define PMX_MODE_STATIC     2'h0
`define PMX_MODE_RT         2'h1
`define PMX_MODE_AUTO       2'h2
`define PMX_MODE_PACED      2'h3

// ----------------------------------------------------------------
// command response byte layout, rotation depth, timing
// ----------------------------------------------------------------
`define PMX_RSP_ACK_LSB     0
`define PMX_RSP_FLD_LSB     2
`define PMX_RSP_MODE_LSB    5
`define PMX_ROT_DEPTH       4'h9
`define PMX_AD_PERIOD_MS    58
`define PMX_CLK_HZ          40000000

`endif

/* File: hdl/pmx_slot_exchange.v */
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pmx_slot_exchange_regs.vh"

// Operation
// - group 0 with block transfer: all words invalid
// - block transfer: words 0-1 reserved, shifted slots
// - integer slot: weight+status in, value+command out
// - slot command bits choose reported weight
// - float slot: four in, four out words
// - float input: response, value pair, status
// - float output: reserved, command, value pair; second slot here: command word 4, value pair 5-6
// - command seen only on changed word
// - acknowledge bits change on each command
// - response shows which quantity is reported
// - real-time value refreshed every a/d update
// - static value latched once, held
// - rotation list of nine, appended by command
// - auto rotation steps each a/d update
// - paced rotation steps on commands 1/2
// - rotation kept across bus reset, cleared at power-on reset
// - empty rotation reports gross only
// - float high word first, fixed order
// - values are ieee single precision
module pmx_slot_exchange (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         por_n,
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output wire         pready,
   output wire         pslverr,
   input  wire         ad_tick,
   input  wire [127:0] plc_out_words,
   output wire [127:0] plc_in_words,
   input  wire [15:0]  int_gross,
   input  wire [15:0]  int_net,
   input  wire [15:0]  int_tare,
   input  wire [15:0]  scale_status,
   input  wire [31:0]  fp_gross,
   input  wire [31:0]  fp_net,
   input  wire [31:0]  fp_tare,
   input  wire [31:0]  fp_target,
   input  wire [31:0]  fp_feed,
   input  wire [31:0]  fp_tol,
   output wire         div_mode,
   output reg          ld_target,
   output reg          ld_tare,
   output reg  [31:0]  ld_value
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   reg  [127:0] out_s1_q;
   reg  [127:0] out_s2_q;
   reg  [1:0]   init_q;
   reg  [7:0]   ctrl_q;
   reg  [3:0]   rot_len_q;
   reg  [26:0]  rot_q;
   wire         init_done;
   wire [1:0]   fmt;
   wire         bt_en;
   wire [1:0]   sq;
   wire [2:0]   nslot;
   wire         is_flt;
   wire [1:0]   add_p;
   wire [1:0]   clr_p;
   wire [1:0]   tgt_p;
   wire [1:0]   tar_p;
   wire [5:0]   add_f;
   wire [63:0]  slot_val;
   wire         acc;

   assign init_done = (init_q == 2'h3);
   assign fmt       = ctrl_q[`PMX_CTRL_FMT_LSB +: 2];
   assign bt_en     = ctrl_q[`PMX_CTRL_BT_BIT];
   assign sq        = ctrl_q[`PMX_CTRL_SQ_LSB +: 2];
   assign nslot     = ctrl_q[`PMX_CTRL_NS_LSB +: 3];
   assign is_flt    = (fmt == `PMX_FMT_FLT);
   assign div_mode  = (fmt == `PMX_FMT_DIV);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // float of a quantity code, ieee single precision from the scale
   // pass ieee values
   function [31:0] f_val;
      input [2:0] f;
      begin
         case (f)
            `PMX_FLD_GROSS:  f_val = fp_gross;
            `PMX_FLD_NET:    f_val = fp_net;
            `PMX_FLD_TARE:   f_val = fp_tare;
            `PMX_FLD_TARGET: f_val = fp_target;
            `PMX_FLD_FEED:   f_val = fp_feed;
            `PMX_FLD_TOL:    f_val = fp_tol;
            default:         f_val = fp_gross;
         endcase
      end
   endfunction

   // quantity at a rotation index
   function [2:0] f_rot;
      input [3:0]  i;
      input [3:0]  n;
      input [26:0] r;
      begin
         if (n == 4'h0) begin
            f_rot = `PMX_FLD_GROSS;
         end else begin
            f_rot = r[i*3 +: 3];
         end
      end
   endfunction

   // next rotation index with wrap
   function [3:0] f_adv;
      input [3:0] i;
      input [3:0] n;
      begin
         if ((n == 4'h0) || (i + 4'h1 >= n)) begin
            f_adv = 4'h0;
         end else begin
            f_adv = i + 4'h1;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // controller word capture
   // ----------------------------------------------------------------
   // two-stage sync; words may tear if the scanner updates mid-cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_s1_q <= 128'h0;
         out_s2_q <= 128'h0;
         init_q   <= 2'h0;
      end else begin
         out_s1_q <= plc_out_words;
         out_s2_q <= out_s1_q;
         if (!init_done) begin
            init_q <= init_q + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // float message slots
   // ----------------------------------------------------------------
   genvar s;
   generate
      for (s = 0; s < 2; s = s + 1) begin : g_slot
         reg  [15:0] prev_q;
         reg  [1:0]  ack_q;
         reg  [2:0]  fld_q;
         reg  [1:0]  mode_q;
         reg  [3:0]  idx_q;
         reg  [31:0] val_q;
         wire [15:0] cmd;
         wire        live;
         wire        fresh;
         wire [3:0]  nidx;

         // command at word 1 or 4
         assign cmd   = out_s2_q[(1 + 3*s)*16 +: 16];
         assign live  = is_flt && ((s == 0) || (nslot > 3'h1));
         assign fresh = init_done && live && (cmd != prev_q);
         assign nidx  = f_adv(idx_q, rot_len_q);
         assign add_p[s] = fresh && (cmd[7:0] == `PMX_CMD_ADD_ROT);
         assign clr_p[s] = fresh && (cmd[7:0] == `PMX_CMD_CLR_ROT);
         assign tgt_p[s] = fresh && (cmd[7:0] == `PMX_CMD_LD_TARGET);
         assign tar_p[s] = fresh && (cmd[7:0] == `PMX_CMD_LD_TARE);
         assign add_f[s*3 +: 3] = cmd[10:8];
         assign slot_val[s*32 +: 32] = val_q;

         // command decode and value refresh
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prev_q <= 16'h0;
               ack_q  <= 2'h0;
               fld_q  <= `PMX_FLD_GROSS;
               mode_q <= `PMX_MODE_RT;
               idx_q  <= 4'h0;
               val_q  <= 32'h0;
            end else if (!init_done || !live) begin
               prev_q <= cmd;
            end else if (fresh) begin
               prev_q <= cmd;
               ack_q  <= ack_q + 2'h1;
               if ((cmd[7:0] == `PMX_CMD_NEXT_A) || (cmd[7:0] == `PMX_CMD_NEXT_B)) begin
                  mode_q <= `PMX_MODE_PACED;
                  idx_q  <= nidx;
                  fld_q  <= f_rot(nidx, rot_len_q, rot_q);
                  val_q  <= f_val(f_rot(nidx, rot_len_q, rot_q));
               end else if (cmd[7:0] == `PMX_CMD_AUTO) begin
                  mode_q <= `PMX_MODE_AUTO;
                  idx_q  <= 4'h0;
                  fld_q  <= f_rot(4'h0, rot_len_q, rot_q);
                  val_q  <= f_val(f_rot(4'h0, rot_len_q, rot_q));
               end else if ((cmd[7:3] == `PMX_CMD_REPORT) && (cmd[2:0] <= `PMX_FLD_TOL)) begin
                  fld_q <= cmd[2:0];
                  val_q <= f_val(cmd[2:0]);
                  if (cmd[2:0] <= `PMX_FLD_NET) begin
                     mode_q <= `PMX_MODE_RT;
                  end else begin
                     mode_q <= `PMX_MODE_STATIC;
                  end
               end
            end else if (ad_tick) begin
               if (mode_q == `PMX_MODE_AUTO) begin
                  idx_q <= nidx;
                  fld_q <= f_rot(nidx, rot_len_q, rot_q);
                  val_q <= f_val(f_rot(nidx, rot_len_q, rot_q));
               end else if (mode_q != `PMX_MODE_STATIC) begin
                  val_q <= f_val(fld_q);
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // rotation store
   // ----------------------------------------------------------------
   // cleared only by the clear command or power-on reset, so a bus reset keeps the list
   // survives bus reset
   always @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         rot_len_q <= 4'h0;
         rot_q     <= 27'h0;
      end else if (clr_p != 2'h0) begin
         rot_len_q <= 4'h0;
      end else if ((add_p != 2'h0) && (rot_len_q < `PMX_ROT_DEPTH)) begin
         // append, slot 1 wins a tie
         rot_len_q <= rot_len_q + 4'h1;
         if (add_p[0]) begin
            rot_q[rot_len_q*3 +: 3] <= add_f[2:0];
         end else begin
            rot_q[rot_len_q*3 +: 3] <= add_f[5:3];
         end
      end
   end

   // ----------------------------------------------------------------
   // load strobes to the terminal
   // ----------------------------------------------------------------
   // operand already in words
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_target <= 1'b0;
         ld_tare   <= 1'b0;
         ld_value  <= 32'h0;
      end else begin
         ld_target <= (tgt_p != 2'h0);
         ld_tare   <= (tar_p != 2'h0);
         if (tgt_p[0] || tar_p[0]) begin
            ld_value <= {out_s2_q[2*16 +: 16], out_s2_q[3*16 +: 16]};
         end else if (tgt_p[1] || tar_p[1]) begin
            ld_value <= {out_s2_q[5*16 +: 16], out_s2_q[6*16 +: 16]};
         end
      end
   end

   // ----------------------------------------------------------------
   // controller input words
   // ----------------------------------------------------------------
   genvar w;
   generate
      for (w = 0; w < 8; w = w + 1) begin : g_word
         reg  [15:0] word_q;
         reg  [15:0] word_d;
         reg  [3:0]  rel;
         reg  [2:0]  lim;
         wire [2:0]  wsel;
         wire [7:0]  rsp;
         // word index held at the width of the relative offset
         localparam [3:0] WIDX = w;

         // int command word sits one position above the weight word
         assign wsel = out_s2_q[((w | 1))*16 +: 3];
         assign rsp  = {1'b0, g_slot[w/4].mode_q, g_slot[w/4].fld_q, g_slot[w/4].ack_q};
         assign plc_in_words[w*16 +: 16] = word_q;

         // word content by format and start quarter
         always @* begin
            word_d = 16'h0;
            rel    = 4'h0;
            lim    = 3'h4 - {1'b0, sq};
            if (nslot < lim) begin
               lim = nslot;
            end
            if (is_flt) begin
               if ((w < 4) || (nslot > 3'h1)) begin
                  case (w % 4)
                     0:       word_d = {rsp, 8'h00};
                     1:       word_d = g_slot[w/4].val_q[31:16];
                     2:       word_d = g_slot[w/4].val_q[15:0];
                     default: word_d = scale_status;
                  endcase
               end
            end else if (bt_en && (sq == 2'h0)) begin
               word_d = 16'h0;
            end else if (w >= 2*sq) begin
               rel = WIDX - {1'b0, sq, 1'b0};
               if (rel[3:1] < lim) begin
                  if (rel[0]) begin
                     word_d = scale_status;
                  end else begin
                     case (wsel)
                        3'h1:    word_d = int_net;
                        3'h2:    word_d = int_tare;
                        default: word_d = int_gross;
                     endcase
                  end
               end
            end
         end

         // registered word image
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               word_q <= 16'h0;
            end else begin
               word_q <= word_d;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   // zero wait states; read data captured in the setup cycle
   assign pready  = 1'b1;
   assign acc     = psel && penable;
   assign pslverr = acc && (paddr != `PMX_CTRL_OFS) && (paddr != `PMX_STAT_OFS) &&
                    (paddr != `PMX_ROT_OFS) && (paddr != `PMX_LOAD_OFS);

   // control register write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `PMX_CTRL_RST;
      end else if (acc && pwrite && (paddr == `PMX_CTRL_OFS)) begin
         ctrl_q <= pwdata[7:0];
      end
   end

   // read mux
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `PMX_CTRL_OFS: prdata <= {24'h0, ctrl_q};
            `PMX_STAT_OFS: prdata <= {16'h0, 1'b0, g_slot[1].mode_q, g_slot[1].fld_q,
                                      g_slot[1].ack_q, 1'b0, g_slot[0].mode_q,
                                      g_slot[0].fld_q, g_slot[0].ack_q};
            `PMX_ROT_OFS:  prdata <= {1'b0, rot_len_q, rot_q};
            `PMX_LOAD_OFS: prdata <= ld_value;
            default:       prdata <= 32'h0;
         endcase
      end
   end

endmodule // pmx_slot_exchange

/* File: verification/pmx_slot_exchange_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the slot exchange
// ----------------------------------------------------------------
module pmx_slot_exchange_properties (
   input wire         pclk,
   input wire         presetn,
   input wire         psel,
   input wire         penable,
   input wire         pwrite,
   input wire         pready,
   input wire [7:0]   paddr,
   input wire [31:0]  pwdata,
   input wire [15:0]  scale_status,
   input wire [127:0] plc_out_words,
   input wire [127:0] plc_in_words
);
   reg  [7:0]  ctrl_q;
   reg  [3:0]  age_q;
   reg  [15:0] cmd_q;
   reg  [3:0]  cmd_age_q;
   // checks wait a few edges after a control write so the map settles
   wire        set = age_q > 4'h4;
   wire        flt = set && ctrl_q[1:0] == 2'h2;
   wire        intf = set && !ctrl_q[1];

   // shadow of the control word and age of slot 1 command word
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q    <= 8'h20;
         age_q     <= 4'h0;
         cmd_q     <= 16'h0;
         cmd_age_q <= 4'hf;
      end else begin
         if (psel && penable && pwrite && pready && paddr == 8'h00) begin
            ctrl_q <= pwdata[7:0];
            age_q  <= 4'h0;
         end else if (age_q != 4'hf) begin
            age_q <= age_q + 4'h1;
         end
         cmd_q <= plc_out_words[31:16];
         if (cmd_q != plc_out_words[31:16])
            cmd_age_q <= 4'h0;
         else if (cmd_age_q != 4'hf)
            cmd_age_q <= cmd_age_q + 4'h1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_ack; $changed(plc_in_words[9:8]); endsequence

   property p_grp0; intf && ctrl_q[2] && ctrl_q[4:3] == 2'h0 |-> plc_in_words == 128'h0; endproperty
   a_grp0: assert property (p_grp0) else $error("group 0 words not cleared");
   property p_rsvd; intf && ctrl_q[2] && ctrl_q[4:3] != 2'h0 |-> plc_in_words[31:0] == 32'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved words not clear");
   property p_istat;
      intf && !ctrl_q[2] && ctrl_q[4:3] == 2'h0 |-> plc_in_words[31:16] == $past(scale_status);
   endproperty
   a_istat: assert property (p_istat) else $error("status word wrong");
   property p_half; flt && ctrl_q[7:5] == 3'h1 |-> plc_in_words[127:64] == 64'h0; endproperty
   a_half: assert property (p_half) else $error("second float slot not clear");
   property p_rsp; flt |-> plc_in_words[7:0] == 8'h0 && !plc_in_words[15]; endproperty
   a_rsp: assert property (p_rsp) else $error("response reserved bits set");
   property p_ack; flt ##0 s_ack |-> cmd_age_q >= 4'h1 && cmd_age_q <= 4'h6; endproperty
   a_ack: assert property (p_ack) else $error("ack without command change");
   property p_cnt; flt ##0 s_ack |-> plc_in_words[9:8] == $past(plc_in_words[9:8]) + 2'h1; endproperty
   a_cnt: assert property (p_cnt) else $error("ack did not step by one");
   property p_static;
      flt && plc_in_words[14:13] == 2'h0 && plc_in_words[12:10] >= 3'h2
         && $stable(plc_in_words[15:8]) |-> $stable(plc_in_words[47:16]);
   endproperty
   a_static: assert property (p_static) else $error("static value moved");
endmodule // pmx_slot_exchange_properties

/* File: verification/pmx_plc_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// controller model: scans input words, writes output words
// ----------------------------------------------------------------
module pmx_plc_model (
   input  wire          pclk,
   input  wire  [127:0] plc_in_words,
   output logic [127:0] plc_out_words
);
   // command word starts non-zero so the reset baseline is exercised
   initial plc_out_words = 128'h0011_0000;

   // write one output word just after an edge
   task automatic put(input int w, input logic [15:0] v);
      @(posedge pclk);
      plc_out_words[16*w +: 16] <= v;
   endtask

   // float command on slot s; lag stretches the operand lead time
   task automatic fcmd(input int s, input logic [15:0] c, input logic [31:0] op,
                       input int lag, output logic ok);
      logic [1:0] ack0;
      int         n;
      ack0 = plc_in_words[64*s+8 +: 2];
      n = 0;
      put(3*s+2, op[31:16]);
      put(3*s+3, op[15:0]);
      repeat (lag) @(posedge pclk);
      put(3*s+1, c);
      do begin
         @(posedge pclk);
         n++;
      end while (plc_in_words[64*s+8 +: 2] === ack0 && n < 16);
      ok = (n < 16);
   endtask
endmodule // pmx_plc_model

/* File: verification/pmx_slot_exchange_test.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// slot exchange bench
// ----------------------------------------------------------------
module pmx_slot_exchange_test;
   logic         pclk, presetn, por_n, psel, penable, pwrite, ad_tick, err;
   logic [7:0]   paddr;
   logic [6:0]   f1;
   logic [31:0]  pwdata, q, fp_gross, fp_net, fp_tare, fp_target, fp_feed, fp_tol;
   logic [15:0]  int_gross, int_net, int_tare, scale_status;
   wire  [31:0]  prdata, ld_value;
   wire  [127:0] plc_out_words, plc_in_words;
   wire          pready, pslverr, div_mode, ld_target, ld_tare;
   int           mismatches, cmp_count, cyc, nld, ntr;

   pmx_slot_exchange u_pmx_slot_exchange (.pclk(pclk), .presetn(presetn), .por_n(por_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ad_tick(ad_tick),
      .plc_out_words(plc_out_words), .plc_in_words(plc_in_words), .int_gross(int_gross),
      .int_net(int_net), .int_tare(int_tare), .scale_status(scale_status),
      .fp_gross(fp_gross), .fp_net(fp_net), .fp_tare(fp_tare), .fp_target(fp_target),
      .fp_feed(fp_feed), .fp_tol(fp_tol), .div_mode(div_mode), .ld_target(ld_target),
      .ld_tare(ld_tare), .ld_value(ld_value));
   pmx_plc_model u_pmx_plc_model (.pclk(pclk), .plc_in_words(plc_in_words),
      .plc_out_words(plc_out_words));

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one apb transfer; q and err taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cfg(input logic [31:0] d);
      apb(1'b1, 8'h00, d);
      repeat (6) @(posedge pclk);
   endtask
   task automatic rst(input logic keep);
      @(posedge pclk);
      presetn <= 1'b0;
      por_n <= keep;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
   task automatic tick;
      @(posedge pclk);
      ad_tick <= 1'b1;
      @(posedge pclk);
      ad_tick <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   task automatic cmd(input logic [15:0] c, input logic [31:0] op = 0, input int lag = 0,
                      input int s = 0);
      logic ok;
      u_pmx_plc_model.fcmd(s, c, op, lag, ok);
      chk("ack", ok, 1);
   endtask

   task automatic t_regs;
      apb(1'b0, 8'h00, 0);
      chk("ctrl rst", q, 32'h20);
      apb(1'b1, 8'h08, 32'hffffffff);
      apb(1'b0, 8'h08, 0);
      chk("rot rst", q, 0);
      apb(1'b0, 8'h10, 0);
      chk("unmapped", {err, q[30:0]}, 32'h80000000);
   endtask
   task automatic t_int;
      logic [15:0] wt [3];
      wt = '{int_gross, int_net, int_tare};
      cfg(32'h41);
      // integer value word written, weight map must not move
      u_pmx_plc_model.put(2, 16'h0064);
      chk("div", div_mode, 1);
      for (int k = 2; k >= 0; k--) begin
         u_pmx_plc_model.put(3, k);
         repeat (6) @(posedge pclk);
         chk("int wt", plc_in_words[47:32], wt[k]);
      end
      chk("slot1 wt", plc_in_words[15:0], int_net);
      chk("int stat", plc_in_words[31:16], scale_status);
      cfg(32'h04);
      chk("grp0", plc_in_words == 0, 1);
      cfg(32'h8c);
      chk("rsvd", plc_in_words[31:0], 0);
      chk("bt wt", plc_in_words[47:32], int_gross);
      chk("bt stat", plc_in_words[127:112], scale_status);
   endtask
   task automatic t_flt;
      cfg(32'h22);
      chk("baseline", plc_in_words[9:8], 0);
      cmd(16'h0010);
      chk("gross rsp", plc_in_words[14:8], 7'h21);
      chk("gross val", {plc_in_words[31:16], plc_in_words[47:32]}, fp_gross);
      chk("low byte", plc_in_words[7:0], 0);
      fp_gross <= 32'h40490fdb;
      tick;
      chk("rt val", {plc_in_words[31:16], plc_in_words[47:32]}, 32'h40490fdb);
      nld = 0;
      cmd(16'h0006, 32'h41200000, 3);
      repeat (4) @(posedge pclk);
      chk("ld pulse", nld, 1);
      apb(1'b0, 8'h0c, 0);
      chk("ld val", q, 32'h41200000);
      cmd(16'h0013);
      chk("tgt rsp", plc_in_words[14:8], 7'h0f);
      fp_target <= 32'hc0000000;
      tick;
      chk("static", {plc_in_words[31:16], plc_in_words[47:32]}, 32'h42c80000);
      nld = 0;
      ntr = 0;
      cmd(16'h0007, 32'h3f000000, 1);
      repeat (4) @(posedge pclk);
      chk("tare pulse", ntr, 1);
      chk("tare only", nld, 0);
      apb(1'b0, 8'h0c, 0);
      chk("tare val", q, 32'h3f000000);
   endtask
   task automatic t_rot;
      cmd(16'h0005);
      apb(1'b0, 8'h08, 0);
      chk("rot clr", q, 0);
      cmd(16'h0001);
      chk("dflt", plc_in_words[12:10], 0);
      for (int i = 0; i < 10; i++)
         cmd({5'h0, 3'(i % 6), 8'h08});
      apb(1'b0, 8'h08, 0);
      chk("rot len", q[30:27], 9);
      chk("rot head", q[5:0], 6'h08);
      cmd(16'h0002);
      f1 = plc_in_words[14:8];
      cmd(16'h0001);
      chk("paced", plc_in_words[14:13] == 2'h3 && plc_in_words[12:10] != f1[4:2], 1);
      cmd(16'h0003);
      f1 = plc_in_words[14:8];
      repeat (10) @(posedge pclk);
      chk("auto hold", plc_in_words[12:8], f1[4:0]);
      tick;
      chk("auto step", plc_in_words[14:13] == 2'h2 && plc_in_words[12:10] != f1[4:2], 1);
      // second float slot: report tolerance on words 4-7
      cfg(32'h42);
      cmd(16'h0015, 0, 0, 1);
      chk("s2 rsp", plc_in_words[78:72], 7'h15);
      chk("s2 val", {plc_in_words[95:80], plc_in_words[111:96]}, fp_tol);
      apb(1'b0, 8'h04, 0);
      chk("s2 stat", q[14:8], 7'h15);
   endtask
   task automatic t_nv;
      rst(1'b1);
      apb(1'b0, 8'h08, 0);
      chk("rot kept", q[30:27], 9);
      rst(1'b0);
      apb(1'b0, 8'h08, 0);
      chk("rot por", q[30:27], 0);
   endtask

   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // load pulse count and hang guard
   always @(posedge pclk) begin
      cyc++;
      nld += (ld_target === 1'b1);
      ntr += (ld_tare === 1'b1);
      if (cyc == 20000) begin
         mismatches++;
         close_out;
      end
   end
   initial begin
      {presetn, por_n, psel, penable, pwrite, ad_tick} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      {int_gross, int_net, int_tare, scale_status} = 64'h0123_0456_0789_5a0c;
      {fp_gross, fp_net, fp_tare} = 96'h3fc00000_40000000_3f800000;
      {fp_target, fp_feed, fp_tol} = 96'h42c80000_40a00000_3dcccccd;
      rst(1'b0);
      t_regs;
      t_int;
      t_flt;
      t_rot;
      t_nv;
      close_out;
   end
endmodule // pmx_slot_exchange_test

bind pmx_slot_exchange pmx_slot_exchange_properties u_pmx_slot_exchange_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .paddr(paddr), .pwdata(pwdata), .scale_status(scale_status),
   .plc_out_words(plc_out_words), .plc_in_words(plc_in_words));
